// >>> testbench/extended_serial_frame_config_tb_top.sv
// self-checking bench of the extended serial frame configuration block
// assumes the register map of the package; index 0 data low, 3 extended control, 4 status, 7 standard control
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module extended_serial_frame_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00, rdata, rv, csz, ctl, stdc;
    logic fv, flong, ferr, fbusy, tx_start, size_ok, ext_on, man_on, sync_on, mode_res, msb_on, par_on, bit_tick, done;
    logic [16:0] fbits, tx_word;
    logic [1:0] fstop, rx_stops, tx_stops, last_stop = 2'h0;
    logic [4:0] tx_bits, rx_bits;
    logic [31:0] rnd = 32'h0000_ceff, r;
    int miscompares = 0, num_checks = 0, n;
    int codes[12] = '{0, 1, 2, 3, 7, 8, 9, 10, 11, 14, 14, 15};
    logic [7:0] rst_exp[8] = '{8'h00, 8'h04, 8'h33, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

    always #2.5 clk = ~clk;

    serial_frame_source src (.clk(clk), .valid(fv), .bits(fbits), .long_frame(flong), .code_err(ferr),
        .stop(fstop), .busy(fbusy));
    ext_serial_frame_config DUT (.clk(clk), .rst_n(rst_n), .ce(ce), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .rx_frame_valid(fv), .rx_frame_bits(fbits), .rx_frame_long(flong),
        .rx_frame_code_err(ferr), .rx_frame_stop(fstop), .rx_busy(fbusy), .tx_start(tx_start),
        .tx_word(tx_word), .tx_bits(tx_bits), .rx_bits(rx_bits), .rx_size_ok(size_ok), .ext_on(ext_on),
        .manchester_on(man_on), .sync_on(sync_on), .mode_reserved(mode_res), .msb_first(msb_on),
        .parity_active(par_on), .rx_stop_count(rx_stops), .tx_stop_count(tx_stops), .bit_tick(bit_tick),
        .rx_done_flag(done));

    function logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction
    function automatic int sz(input int c);
        if (c < 4 || (c >= 8 && c < 12)) return 5 + c;
        if (c == 7) return 9;
        if (c >= 14) return 17;
        return 0;
    endfunction
    // reversal within the width is its own inverse, so one map serves both directions
    function automatic logic [16:0] wmap(input logic [16:0] v, input int w, input logic m);
        logic [16:0] o;
        o = '0;
        for (int i = 0; i < w; i++) o[i] = m ? v[w-1-i] : v[i];
        return o;
    endfunction

    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic cfg();
        wr_reg(3'h2, csz);
        wr_reg(3'h3, ctl);
        wr_reg(3'h7, stdc);
    endtask
    task automatic chk_modes();
        logic e, c, s, m;
        int rc;
        e = ctl[4]; c = ctl[1]; s = stdc[1]; m = e & c & !s; rc = csz[3:0];
        #1;
        `CHK("ext", e, ext_on)
        `CHK("manch", m, man_on)
        `CHK("rsvd", e & c & s, mode_res)
        `CHK("sync", s, sync_on)
        `CHK("order", e & ctl[0], msb_on)
        `CHK("rxstop", (e & ctl[3]) ? 2'h2 : 2'h1, rx_stops)
        `CHK("txstop", stdc[0] ? 2'h2 : 2'h1, tx_stops)
        `CHK("parity", (stdc[3:2] != 2'h0) & !m, par_on)
        `CHK("rxbits", 5'(sz(rc)), rx_bits)
        `CHK("txbits", 5'(sz(csz[7:4])), tx_bits)
        `CHK("sizeok", sz(rc) != 0 && (rc != 14 || m) && (e || sz(rc) <= 9), size_ok)
    endtask
    task automatic rx_check(input int code, input logic man);
        logic e, lg, er, ex;
        logic [1:0] st;
        logic [16:0] b, v;
        logic [7:0] hi;
        int w, i;
        e = ctl[4]; b = xs(); r = xs(); er = r[0]; st = r[2:1];
        lg = code == 15 || (code == 14 && b[16]);
        w = code == 14 ? (lg ? 17 : 16) : sz(code);
        b = b & ((17'h1 << w) - 17'h1);
        src.send(b, lg, er, st);
        i = 0;
        while (done !== 1'b1 && i < 10) begin
            @(posedge clk);
            #1 i++;
        end
        if (i == 10) begin
            miscompares++;
            summarize();
        end
        v = wmap(b, w, e & ctl[0]);
        if (man) last_stop = st;
        hi = w == 9 ? (e ? {7'h0, v[8]} : 8'h00) : (w >= 13 ? v[15:8] : 8'h00);
        ex = (w == 9 && !e) ? v[8] : (w >= 13 ? v[16] : 1'b0);
        rd_reg(3'h4, rv); `CHK("status", {4'h0, man & er, man & lg & (code == 14), last_stop}, rv)
        rd_reg(3'h1, rv); `CHK("high", hi, rv)
        rd_reg(3'h7, rv); `CHK("extra", {1'b1, ex}, {rv[7], rv[4]})
        rd_reg(3'h0, rv); `CHK("low", v[7:0], rv)
        `CHK("done", 1'b0, done)
    endtask

    initial begin
        repeat (100000) @(posedge clk);
        miscompares++;
        summarize();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            rd_reg(3'(i), rv); `CHK("reset", rst_exp[i], rv)
        end
        for (int i = 3; i < 7; i++) wr_reg(3'(i), 8'hff);
        rd_reg(3'h3, rv); `CHK("ctrl", 8'h1b, rv)
        rd_reg(3'h4, rv); `CHK("stat ro", 8'h00, rv)
        rd_reg(3'h5, rv); `CHK("div lo", 8'hff, rv)
        rd_reg(3'h6, rv); `CHK("div hi", 8'hff, rv)
        @(posedge clk) ce <= 1'b0;
        wr_reg(3'h3, 8'h00);
        ce <= 1'b1;
        rd_reg(3'h3, rv); `CHK("frozen", 8'h1b, rv)
        for (int i = 0; i < 64; i++) begin
            r = xs();
            csz = {r[7:4], 4'(i)};
            ctl = {r[15:13], i[4], r[11:10], i[5], r[8]};
            stdc = r[23:16];
            cfg();
            chk_modes();
        end
        for (int k = 0; k < 24; k++) begin
            r = xs();
            n = k < 12 ? codes[k] : (k < 18 ? codes[k-12] : (k % 2 ? 7 : 3));
            ctl = k < 12 ? {4'h1, r[1], 3'h2} | {7'h0, r[0]} : (k < 18 ? 8'h10 : 8'h00) | {7'h0, r[0]};
            csz = {4'h3, 4'(n)};
            // parity none before line coding is used
            stdc = 8'h00;
            cfg();
            rx_check(n, k < 12);
        end
        for (int k = 0; k < 6; k++) begin
            r = xs();
            n = k % 4 == 0 ? 7 : codes[k * 2 + 1];
            ctl = k < 4 ? {7'h08, r[0]} : 8'h00;
            csz = {4'(n), 4'h3};
            stdc = {3'h0, r[31], 4'h0};
            cfg();
            wr_reg(3'h1, r[15:8]);
            wr_reg(3'h0, r[23:16]);
            #1;
            `CHK("txgo", 1'b1, tx_start)
            if (sz(n) == 9 && !ctl[4]) r[8] = r[31];
            `CHK("txword", wmap({r[31], r[15:8], r[23:16]} & ((17'h1 << sz(n)) - 17'h1), sz(n), ctl[0]),
                tx_word)
            @(posedge clk);
            #1 `CHK("txgo", 1'b0, tx_start)
        end
        ctl = 8'h12;
        cfg();
        // divisor set while the line is idle
        wr_reg(3'h5, 8'h03);
        wr_reg(3'h6, 8'h00);
        n = 0;
        fork
            src.hold_busy(60);
            begin
                repeat (10) @(posedge clk);
                repeat (40) @(posedge clk) #1 n += int'(bit_tick);
            end
        join
        `CHK("ticks", 10, n)
        n = 0;
        repeat (2) @(posedge clk);
        repeat (8) @(posedge clk) #1 n += int'(bit_tick);
        `CHK("idle", 0, n)
        summarize();
    end
endmodule

// >>> testbench/serial_frame_source.sv
// stand-in for the serial core and the remote node behind it: hands over whole received frames
// assumes the bench calls its tasks from one process, just after a rising clock edge
module serial_frame_source (
    input wire logic clk,
    output logic valid,
    output logic [ext_serial_pkg::DATA_W-1:0] bits,
    output logic long_frame,
    output logic code_err,
    output logic [1:0] stop,
    output logic busy
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        valid = 1'b0;
        bits = '0;
        long_frame = 1'b0;
        code_err = 1'b0;
        stop = 2'h0;
        busy = 1'b0;
    end

    task automatic send(input logic [16:0] b, input logic l, input logic e, input logic [1:0] s);
        @(posedge clk);
        busy <= 1'b1;
        repeat (4) @(posedge clk);
        valid <= 1'b1;
        bits <= b;
        long_frame <= l;
        code_err <= e;
        stop <= s;
        @(posedge clk);
        valid <= 1'b0;
        busy <= 1'b0;
        // stale frame fields are inverted so that a late sample cannot pass by luck
        bits <= ~b;
        long_frame <= ~l;
        code_err <= ~e;
        stop <= ~s;
    endtask

    task automatic hold_busy(input int n);
        @(posedge clk);
        busy <= 1'b1;
        repeat (n) @(posedge clk);
        busy <= 1'b0;
    endtask
endmodule

// >>> verilog/bit_order_map.sv
// maps a frame word between register order and wire order, zeroing bits above the size
// assumes nbits never exceeds W; bit 0 of the wire side is the first bit on the line
module bit_order_map #(
    parameter int W = 17
) (
    input wire logic [W-1:0] word,
    input wire logic [4:0] nbits,
    input wire logic msb_first,
    output logic [W-1:0] mapped
);
    if (W < 17 || W > 31) begin : g_chk
        $error("bit_order_map width out of range");
    end

    always_comb begin
        mapped = '0;
        for (int i = 0; i < W; i++) begin
            if (i < int'(nbits)) begin
                mapped[i] = msb_first ? word[int'(nbits) - 1 - i] : word[i];
            end
        end
    end
endmodule

// >>> verilog/bit_period_timer.sv
// bit-period timer of the Manchester receiver
// assumes the divisor stays steady while run is high
module bit_period_timer #(
    parameter int CW = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic run,
    input wire logic [CW-1:0] divisor,
    output logic tick
);
    logic [CW-1:0] count;
    logic [CW-1:0] next_count;
    logic next_tick;

    if (CW < 1 || CW > 16) begin : g_chk
        $error("bit_period_timer counter width out of range");
    end

    always_comb begin
        next_count = count;
        next_tick = 1'b0;
        if (!run) begin
            next_count = '0;
        end else if (count >= divisor) begin
            next_count = '0;
            next_tick = 1'b1;
        end else begin
            next_count = count + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
            tick <= 1'b0;
        end else if (ce) begin
            count <= next_count;
            tick <= next_tick;
        end
    end

    tick_at_term_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && run && count == divisor) |=> tick) else $error("no tick at terminal count");
    wrap_zero_a: assert property (@(posedge clk) disable iff (!rst_n)
        (ce && tick) |-> count == '0) else $error("timer did not restart after tick");
    tick_seen_c: cover property (@(posedge clk) disable iff (!rst_n) run && tick);
endmodule

// >>> verilog/ext_serial_frame_config.sv
// configuration and status registers of the extended serial port
// assumes the serial core hands over whole received frames, first line bit in bit 0,
// and sends tx_word bit 0 first; register port answers reads one cycle later
//
// Added by the designer: the strobed register port and the register addresses.
module ext_serial_frame_config (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [ext_serial_pkg::ADDR_W-1:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    input wire logic rx_frame_valid,
    input wire logic [ext_serial_pkg::DATA_W-1:0] rx_frame_bits,
    input wire logic rx_frame_long,
    input wire logic rx_frame_code_err,
    input wire logic [1:0] rx_frame_stop,
    input wire logic rx_busy,
    output logic tx_start,
    output logic [ext_serial_pkg::DATA_W-1:0] tx_word,
    output logic [4:0] tx_bits,
    output logic [4:0] rx_bits,
    output logic rx_size_ok,
    output logic ext_on,
    output logic manchester_on,
    output logic sync_on,
    output logic mode_reserved,
    output logic msb_first,
    output logic parity_active,
    output logic [1:0] rx_stop_count,
    output logic [1:0] tx_stop_count,
    output logic bit_tick,
    output logic rx_done_flag
);
    localparam int W = ext_serial_pkg::DATA_W;

    // software-visible registers
    logic [7:0] rx_low;
    logic [7:0] rx_high;
    logic [7:0] tx_high;
    logic [7:0] char_size;
    logic [7:0] ext_ctrl;
    logic [7:0] ext_stat;
    logic [15:0] divisor;
    logic tx_stop_sel;
    logic sync_sel;
    logic tx_extra;
    logic rx_extra;
    logic [1:0] parity_sel;

    // next values, all registered together under ce
    logic [7:0] next_rx_low;
    logic [7:0] next_rx_high;
    logic [7:0] next_tx_high;
    logic [7:0] next_char_size;
    logic [7:0] next_ext_ctrl;
    logic [7:0] next_ext_stat;
    logic [15:0] next_divisor;
    logic next_tx_stop_sel;
    logic next_sync_sel;
    logic next_tx_extra;
    logic next_rx_extra;
    logic next_done;
    logic next_tx_start;
    logic [1:0] next_parity_sel;
    logic [7:0] next_rdata;
    logic [W-1:0] next_tx_word;

    // decode and data paths
    logic [3:0] rx_code;
    logic [3:0] tx_code;
    logic [4:0] frame_width;
    logic [W-1:0] rx_mapped;
    logic [W-1:0] tx_raw;
    logic [W-1:0] tx_mapped;
    logic wr_low;

    assign ext_on = ext_ctrl[ext_serial_pkg::CTRL_EXT_EN];
    assign sync_on = sync_sel;
    assign manchester_on = ext_on && ext_ctrl[ext_serial_pkg::CTRL_LINE_CODING] && !sync_sel;
    assign mode_reserved = ext_on && ext_ctrl[ext_serial_pkg::CTRL_LINE_CODING] && sync_sel;
    assign msb_first = ext_on && ext_ctrl[ext_serial_pkg::CTRL_BIT_ORDER];
    assign parity_active = (parity_sel != ext_serial_pkg::PARITY_NONE) && !manchester_on;

    assign rx_code = char_size[3:0];
    assign tx_code = char_size[7:4];
    assign rx_bits = ext_serial_pkg::char_bits(rx_code);
    assign tx_bits = ext_serial_pkg::char_bits(tx_code);

    // standard port limited to nine bits
    always_comb begin
        rx_size_ok = (rx_bits != ext_serial_pkg::BITS_NONE);
        if (!ext_on && rx_bits > ext_serial_pkg::BITS_9) begin
            rx_size_ok = 1'b0;
        end
        if (rx_code == ext_serial_pkg::SZ_16_17 && !manchester_on) begin
            rx_size_ok = 1'b0;
        end
    end

    assign rx_stop_count = (ext_on && ext_ctrl[ext_serial_pkg::CTRL_RX_TWO_STOP]) ?
        ext_serial_pkg::STOP_TWO : ext_serial_pkg::STOP_ONE;
    assign tx_stop_count = tx_stop_sel ? ext_serial_pkg::STOP_TWO : ext_serial_pkg::STOP_ONE;

    // the dual-length code takes its width from what the core actually counted
    assign frame_width = (rx_code == ext_serial_pkg::SZ_16_17) ?
        (rx_frame_long ? ext_serial_pkg::BITS_17 : ext_serial_pkg::BITS_16) : rx_bits;

    bit_order_map #(.W(W)) u_rx_map (
        .word(rx_frame_bits),
        .nbits(frame_width),
        .msb_first(msb_first),
        .mapped(rx_mapped)
    );

    // transmit word assembled from the write that starts it
    assign wr_low = wr && addr == ext_serial_pkg::OFF_DATA_LOW;
    always_comb begin
        tx_raw = {1'b0, tx_high, wdata};
        if (tx_bits == ext_serial_pkg::BITS_9) begin
            tx_raw = {8'h00, ext_on ? tx_high[0] : tx_extra, wdata};
        end else if (tx_bits == ext_serial_pkg::BITS_17) begin
            tx_raw = {tx_extra, tx_high, wdata};
        end
    end

    bit_order_map #(.W(W)) u_tx_map (
        .word(tx_raw),
        .nbits(tx_bits),
        .msb_first(msb_first),
        .mapped(tx_mapped)
    );

    always_comb begin
        next_rx_low = rx_low;
        next_rx_high = rx_high;
        next_tx_high = tx_high;
        next_char_size = char_size;
        next_ext_ctrl = ext_ctrl;
        next_ext_stat = ext_stat;
        next_divisor = divisor;
        next_tx_stop_sel = tx_stop_sel;
        next_sync_sel = sync_sel;
        next_parity_sel = parity_sel;
        next_tx_extra = tx_extra;
        next_rx_extra = rx_extra;
        next_done = rx_done_flag;
        next_tx_start = 1'b0;
        next_tx_word = tx_word;
        next_rdata = 8'h00;

        // writes land at the next edge; status ignores them
        if (wr) begin
            case (addr)
                ext_serial_pkg::OFF_DATA_LOW: begin
                    next_tx_start = 1'b1;
                    next_tx_word = tx_mapped;
                end
                ext_serial_pkg::OFF_DATA_HIGH: next_tx_high = wdata;
                ext_serial_pkg::OFF_CHAR_SIZE: next_char_size = wdata;
                ext_serial_pkg::OFF_EXT_CTRL: next_ext_ctrl = wdata & ext_serial_pkg::CTRL_WMASK;
                // a change mid-frame is not guarded
                ext_serial_pkg::OFF_DIV_LOW: next_divisor[7:0] = wdata;
                ext_serial_pkg::OFF_DIV_HIGH: next_divisor[15:8] = wdata;
                ext_serial_pkg::OFF_STD_CTRL: begin
                    next_tx_stop_sel = wdata[ext_serial_pkg::STD_TX_STOP];
                    next_sync_sel = wdata[ext_serial_pkg::STD_SYNC];
                    next_parity_sel = wdata[ext_serial_pkg::STD_PARITY_LO +: 2];
                    next_tx_extra = wdata[ext_serial_pkg::STD_EXTRA];
                end
                default: next_ext_stat = ext_stat;
            endcase
        end

        // read data stands for one cycle only, zero otherwise
        if (rd) begin
            case (addr)
                ext_serial_pkg::OFF_DATA_LOW: begin
                    next_rdata = rx_low;
                    next_done = 1'b0;
                end
                ext_serial_pkg::OFF_DATA_HIGH: next_rdata = rx_high;
                ext_serial_pkg::OFF_CHAR_SIZE: next_rdata = char_size;
                ext_serial_pkg::OFF_EXT_CTRL: next_rdata = ext_ctrl;
                ext_serial_pkg::OFF_EXT_STAT: next_rdata = ext_stat;
                ext_serial_pkg::OFF_DIV_LOW: next_rdata = divisor[7:0];
                ext_serial_pkg::OFF_DIV_HIGH: next_rdata = divisor[15:8];
                default: next_rdata = {rx_done_flag, 2'h0, rx_extra, parity_sel, sync_sel, tx_stop_sel};
            endcase
        end

        // a frame landing in the cycle the data byte is read keeps the flag set
        if (rx_frame_valid) begin
            next_done = 1'b1;
            next_rx_low = rx_mapped[7:0];
            next_rx_high = 8'h00;
            next_rx_extra = 1'b0;
            if (frame_width == ext_serial_pkg::BITS_9) begin
                if (ext_on) begin
                    next_rx_high = {7'h00, rx_mapped[8]};
                end else begin
                    next_rx_extra = rx_mapped[8];
                end
            end else if (frame_width >= ext_serial_pkg::BITS_13) begin
                // upper bits, unused ones already zero
                next_rx_high = rx_mapped[15:8];
                next_rx_extra = rx_mapped[16];
            end
            next_ext_stat[ext_serial_pkg::STAT_FRAME_ERR] = manchester_on && rx_frame_code_err;
            next_ext_stat[ext_serial_pkg::STAT_LONG] = manchester_on && rx_code == ext_serial_pkg::SZ_16_17
                && rx_frame_long;
            // stop values only for Manchester frames
            if (manchester_on) begin
                next_ext_stat[ext_serial_pkg::STAT_STOP_HI] = rx_frame_stop[1];
                next_ext_stat[ext_serial_pkg::STAT_STOP_LO] = rx_frame_stop[0];
            end
            next_ext_stat[7:4] = ext_serial_pkg::STAT_RSVD_ZERO;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rx_low <= ext_serial_pkg::RST_ZERO8;
            rx_high <= ext_serial_pkg::RST_DATA_HIGH;
            tx_high <= ext_serial_pkg::RST_DATA_HIGH;
            char_size <= ext_serial_pkg::RST_CHAR_SIZE;
            ext_ctrl <= ext_serial_pkg::RST_ZERO8;
            ext_stat <= ext_serial_pkg::RST_ZERO8;
            divisor <= ext_serial_pkg::RST_DIV;
            tx_stop_sel <= 1'b0;
            sync_sel <= 1'b0;
            parity_sel <= ext_serial_pkg::PARITY_NONE;
            tx_extra <= 1'b0;
            rx_extra <= 1'b0;
            rx_done_flag <= 1'b0;
            tx_start <= 1'b0;
            tx_word <= '0;
            rdata <= ext_serial_pkg::RST_ZERO8;
        end else if (ce) begin
            rx_low <= next_rx_low;
            rx_high <= next_rx_high;
            tx_high <= next_tx_high;
            char_size <= next_char_size;
            ext_ctrl <= next_ext_ctrl;
            ext_stat <= next_ext_stat;
            divisor <= next_divisor;
            tx_stop_sel <= next_tx_stop_sel;
            sync_sel <= next_sync_sel;
            parity_sel <= next_parity_sel;
            tx_extra <= next_tx_extra;
            rx_extra <= next_rx_extra;
            rx_done_flag <= next_done;
            tx_start <= next_tx_start;
            tx_word <= next_tx_word;
            rdata <= next_rdata;
        end
    end

    // the timer only runs while a Manchester frame is coming in, so idle lines cost nothing
    bit_period_timer #(.CW(16)) u_timer (
        .clk(clk),
        .rst_n(rst_n),
        .ce(ce),
        .run(manchester_on && rx_busy),
        .divisor(divisor),
        .tick(bit_tick)
    );

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    size_nine_a: assert property (rx_code == ext_serial_pkg::SZ_9 |-> rx_bits == ext_serial_pkg::BITS_9)
        else $error("size code 7 not nine bits");
    dual_len_a: assert property ((rx_code == ext_serial_pkg::SZ_16_17 && !manchester_on) |-> !rx_size_ok)
        else $error("dual length accepted without Manchester");
    std_limit_a: assert property ((!ext_on && rx_bits > ext_serial_pkg::BITS_9) |-> !rx_size_ok)
        else $error("standard port accepted a wide size");
    rx_stop_a: assert property ((ext_on && ext_ctrl[ext_serial_pkg::CTRL_RX_TWO_STOP])
        |-> rx_stop_count == ext_serial_pkg::STOP_TWO) else $error("receiver stop count wrong");
    sync_mch_a: assert property (mode_reserved |-> !manchester_on)
        else $error("Manchester active in synchronous mode");
    frame_err_a: assert property ((ce && rx_frame_valid && manchester_on && rx_frame_code_err)
        |=> ext_stat[ext_serial_pkg::STAT_FRAME_ERR] && rx_done_flag) else $error("framing error not captured");
    err_hold_a: assert property ((ce && !rx_frame_valid) |=> $stable(ext_stat[3:0]))
        else $error("status changed without a frame");
    long_flag_a: assert property ((ce && rx_frame_valid && !manchester_on)
        |=> !ext_stat[ext_serial_pkg::STAT_LONG]) else $error("long flag set for level frame");
    stop_keep_a: assert property ((ce && rx_frame_valid && !manchester_on) |=> $stable(ext_stat[1:0]))
        else $error("stop values updated for level frame");
    stat_rsvd_a: assert property (ext_stat[7:4] == ext_serial_pkg::STAT_RSVD_ZERO)
        else $error("reserved status bits set");
    msb_rx_a: assert property ((ce && rx_frame_valid && msb_first && frame_width == ext_serial_pkg::BITS_8)
        |=> rx_low[7] == $past(rx_frame_bits[0])) else $error("msb-first receive order wrong");
    nine_ext_a: assert property ((ce && rx_frame_valid && ext_on && frame_width == ext_serial_pkg::BITS_9)
        |=> !rx_extra && rx_high[0] == $past(rx_mapped[8])) else $error("ninth bit misplaced");
    tx_go_a: assert property ((ce && wr_low) |=> tx_start ##1 (!tx_start || !$past(ce) || $past(wr_low)))
        else $error("transmit start not a pulse");
    done_clear_a: assert property ((ce && rd && addr == ext_serial_pkg::OFF_DATA_LOW && !rx_frame_valid)
        |=> !rx_done_flag) else $error("done flag not cleared by data read");

    // checks below look one edge after the event that loads a register
    tx_stop_a: assert property ((ce && wr && addr == ext_serial_pkg::OFF_STD_CTRL) |=> tx_stop_count ==
        ($past(wdata[ext_serial_pkg::STD_TX_STOP]) ? ext_serial_pkg::STOP_TWO : ext_serial_pkg::STOP_ONE))
        else $error("wrong transmit stop count");
    div_low_a: assert property ((ce && wr && addr == ext_serial_pkg::OFF_DIV_LOW)
        |=> divisor[7:0] == $past(wdata)) else $error("divisor low byte not written");
    done_set_a: assert property ((ce && rx_frame_valid) |=> rx_done_flag)
        else $error("done flag not set by frame");
    lsb_rx_a: assert property ((ce && rx_frame_valid && !msb_first && frame_width >= ext_serial_pkg::BITS_8)
        |=> rx_low == $past(rx_frame_bits[7:0])) else $error("lsb-first receive order wrong");
    top_bit_a: assert property ((ce && rx_frame_valid && !msb_first && frame_width == ext_serial_pkg::BITS_17)
        |=> rx_extra == $past(rx_frame_bits[16])) else $error("top bit misplaced");
    nine_std_a: assert property ((ce && rx_frame_valid && !ext_on && frame_width == ext_serial_pkg::BITS_9)
        |=> rx_high == ext_serial_pkg::RST_ZERO8 && rx_extra == $past(rx_frame_bits[8]))
        else $error("standard ninth bit misplaced");
    stop_take_a: assert property ((ce && rx_frame_valid && manchester_on)
        |=> ext_stat[1:0] == $past(rx_frame_stop)) else $error("stop values not captured");
    tick_idle_a: assert property ((ce && !(manchester_on && rx_busy)) |=> !bit_tick)
        else $error("bit tick while timer stopped");


    mch_err_c: cover property (ce && rx_frame_valid && manchester_on && rx_frame_code_err);
    long_frame_c: cover property (ce && rx_frame_valid && rx_code == ext_serial_pkg::SZ_16_17 && rx_frame_long);
    msb_tx_c: cover property (ce && wr_low && msb_first && tx_bits == ext_serial_pkg::BITS_17);
    set_clear_c: cover property (ce && rx_frame_valid && rd && addr == ext_serial_pkg::OFF_DATA_LOW);
endmodule

// >>> verilog/ext_serial_pkg.sv
// constants, register map and size decoding of the extended serial frame configuration block
// assumes one 200 MHz clock, an 8-bit register port and a serial core that reports whole frames
package ext_serial_pkg;
    localparam int ADDR_W = 3;
    localparam int DATA_W = 17;
    localparam logic [2:0] OFF_DATA_LOW = 3'h0, OFF_DATA_HIGH = 3'h1, OFF_CHAR_SIZE = 3'h2, OFF_EXT_CTRL = 3'h3;
    localparam logic [2:0] OFF_EXT_STAT = 3'h4, OFF_DIV_LOW = 3'h5, OFF_DIV_HIGH = 3'h6, OFF_STD_CTRL = 3'h7;
    // extended control fields
    localparam int CTRL_EXT_EN = 4, CTRL_RX_TWO_STOP = 3, CTRL_LINE_CODING = 1, CTRL_BIT_ORDER = 0;
    localparam logic [7:0] CTRL_WMASK = 8'h1b;
    // extended status fields
    localparam int STAT_FRAME_ERR = 3, STAT_LONG = 2, STAT_STOP_HI = 1, STAT_STOP_LO = 0;
    localparam logic [3:0] STAT_RSVD_ZERO = 4'h0;
    // standard control fields gathered into one register
    localparam int STD_TX_STOP = 0, STD_SYNC = 1, STD_PARITY_LO = 2, STD_EXTRA = 4, STD_DONE = 7;
    localparam logic [1:0] PARITY_NONE = 2'h0;
    // reset values
    localparam logic [7:0] RST_CHAR_SIZE = 8'h33, RST_DATA_HIGH = 8'h04, RST_ZERO8 = 8'h00;
    localparam logic [15:0] RST_DIV = 16'h0000;
    // size codes and widths
    localparam logic [3:0] SZ_9 = 4'h7, SZ_16_17 = 4'he, SZ_17 = 4'hf;
    localparam logic [4:0] BITS_NONE = 5'h00, BITS_5 = 5'h05, BITS_8 = 5'h08, BITS_9 = 5'h09;
    localparam logic [4:0] BITS_13 = 5'h0d, BITS_16 = 5'h10, BITS_17 = 5'h11;
    localparam logic [1:0] STOP_ONE = 2'h1, STOP_TWO = 2'h2;

    function automatic logic [4:0] char_bits(input logic [3:0] code);
        logic [4:0] n;
        n = BITS_NONE;
        case (code)
            4'h0, 4'h1, 4'h2, 4'h3: n = BITS_5 + {3'h0, code[1:0]};
            SZ_9: n = BITS_9;
            4'h8, 4'h9, 4'ha, 4'hb: n = BITS_13 + {3'h0, code[1:0]};
            SZ_16_17, SZ_17: n = BITS_17;
            default: n = BITS_NONE;
        endcase
        return n;
    endfunction
endpackage
